// file: ldc_defs.svh
// constants for the led backlight dimming control block
// Summary of operation
// - brightness follows the pwm pin after reset; host may select serial brightness
// - with i2c active, address select pin picks one of two slave addresses
// - cluster mode gives each channel its own host-written brightness, except that a split display group shares channel 0's
// - faults show on interrupt output; host clears latched status over serial bus
// - a falling edge on the logic supply input also clears latched status
// - pure pwm dimming after reset; host may select hybrid duty plus current dimming
// - each channel current is full scale times its 12-bit scale field
// - detect connected strings and phase shift them by 360 over string count
// - unused outputs stay off, leave boost monitoring, raise no open or short faults
// - cluster: six individual channels, or 3 to 5 display plus 3 to 1 indicators
// - watch every active, unfaulted output headroom and steer boost to the lowest sufficient level
// - flag open, short, boost ocp/ovp, supply uv, input ovp/uv/ocp, overtemperature
// - die temperature is readable and leaving a programmable window is flagged
// - interface select pin high chooses i2c, low chooses spi
`ifndef LDC_DEFS_SVH
`define LDC_DEFS_SVH

`define LDC_NCH 6
`define LDC_DUTY_W 10
`define LDC_CUR_W 12
`define LDC_HYB_KNEE 10'h100
`define LDC_FULL_DUTY 11'h400
// pin sync bit positions
`define LDC_PIN_PWM 0
`define LDC_PIN_IFSEL 1
`define LDC_PIN_ADDR 2
`define LDC_PIN_VDD 3
// fault status bit positions
`define LDC_FLT_OPEN 0
`define LDC_FLT_SHORT 6
`define LDC_FLT_BOCP 12
`define LDC_FLT_BOVP 13
`define LDC_FLT_VDDUV 14
`define LDC_FLT_VINOVP 15
`define LDC_FLT_VINUV 16
`define LDC_FLT_VINOCP 17
`define LDC_FLT_TSD 18
`define LDC_FLT_TWIN 19
`define LDC_FLT_W 20
// i2c slave addresses, values arbitrary
`define LDC_I2C_ADDR0 7'h2_C
`define LDC_I2C_ADDR1 7'h2_D
// string detection wait after reset
`define LDC_CLK_NS 100
`define LDC_DETECT_US 50
`define LDC_DETECT_CYC ((`LDC_DETECT_US * 1000) / `LDC_CLK_NS)

`endif

// file: ldc_pkg.sv
// types for the led backlight dimming control block
package ldc_pkg;
  typedef enum logic [1:0] {
    LDC_DETECT = 2'b01,
    LDC_RUN = 2'b10
  } ldc_phase_t;

  typedef struct packed {
    logic pwm;
    logic [11:0] cur;
  } ldc_chan_state_t;

  typedef struct packed {
    ldc_phase_t phase;
    logic [9:0] det_cnt;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_s3;
    logic [3:0] pin_f;
    logic [3:0] pin_q;
    logic [9:0] cnt;
    logic [9:0] hi_cnt;
    logic [9:0] pwm_brt;
    logic [5:0] present;
    logic [19:0] flt;
    logic int_oe;
    logic i2c_sel;
    logic [6:0] i2c_addr;
    logic boost_up;
    logic boost_down;
    logic [11:0] temp;
  } ldc_state_t;
endpackage

// file: ldc_chan.sv
// one led channel: phase shifted pwm and current amplitude
`include "ldc_defs.svh"
module ldc_chan (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [9:0] cnt_i,
  input wire logic [9:0] offset_i,
  input wire logic [9:0] brt_i,
  input wire logic [11:0] scale_i,
  input wire logic hybrid_i,
  input wire logic enable_i,
  output logic pwm_o,
  output logic [11:0] cur_o
);
  ldc_pkg::ldc_chan_state_t s, next_s;
  logic [9:0] phase;
  logic [10:0] duty;
  logic [21:0] prod;

  always_comb begin
    phase = cnt_i - offset_i;
    prod = scale_i * brt_i;
    next_s = s;
    if (hybrid_i && brt_i >= `LDC_HYB_KNEE) begin
      // high range dims by amplitude only, fewer edges means less emi
      duty = `LDC_FULL_DUTY;
      next_s.cur = prod[21:10];
    end else if (hybrid_i) begin
      duty = {brt_i[8:0], 2'b00};
      next_s.cur = {2'b00, scale_i[11:2]};
    end else begin
      duty = {1'b0, brt_i};
      next_s.cur = scale_i;
    end
    next_s.pwm = enable_i && ({1'b0, phase} < duty);
    if (!enable_i) begin
      next_s.cur = 12'h000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pwm_o = s.pwm;
  assign cur_o = s.cur;

  chk_unused_dark: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !enable_i |=> !pwm_o && cur_o == 12'h000) else $error("disabled channel lit");
endmodule // ldc_chan

// file: ldc_top.sv
// led backlight dimming control: brightness, phase, boost steering, faults
`include "ldc_defs.svh"
module ldc_top (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic pwm_in_i,
  input wire logic if_sel_i,
  input wire logic address_select_pin_i,
  input wire logic vdd_i,
  input wire logic brt_src_serial_i,
  input wire logic [15:0] disp_brt_i,
  input wire logic hybrid_en_i,
  input wire logic cluster_en_i,
  input wire logic [2:0] cluster_group_i,
  input wire logic [95:0] chan_brt_i,
  input wire logic [71:0] channel_current_scale_i,
  input wire logic [5:0] string_present_i,
  input wire logic [5:0] headroom_low_i,
  input wire logic [5:0] headroom_high_i,
  input wire logic [5:0] open_i,
  input wire logic [5:0] short_i,
  input wire logic boost_ocp_i,
  input wire logic boost_ovp_i,
  input wire logic vdd_uv_i,
  input wire logic vin_ovp_i,
  input wire logic vin_uv_i,
  input wire logic vin_ocp_i,
  input wire logic tsd_i,
  input wire logic [11:0] temp_i,
  input wire logic [11:0] temp_lo_i,
  input wire logic [11:0] temp_hi_i,
  input wire logic fault_clr_i,
  output logic i2c_sel_o,
  output logic [6:0] i2c_addr_o,
  output logic [5:0] led_pwm_o,
  output logic [71:0] led_current_o,
  output logic [5:0] strings_o,
  output logic boost_up_o,
  output logic boost_down_o,
  output logic [19:0] fault_status_o,
  output logic [11:0] temp_o,
  output logic int_n_o,
  output logic int_n_oe_o
);
  // ==========================================================
  // state
  ldc_pkg::ldc_state_t s, next_s;
  logic [9:0] brt_global;
  logic [9:0] ch_brt [6];
  logic [9:0] ch_off [6];
  logic [2:0] rank [6];
  logic [9:0] step;
  logic [5:0] active;
  logic [5:0] monitored;
  logic [19:0] flt_set;
  logic vdd_fall;
  logic clr;
  logic grp_split;
  logic [12:0] off_full;

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;
    off_full = 13'h0000;
    // three stage pin sync, a change counts when stages two and three agree
    next_s.pin_s1 = {vdd_i, address_select_pin_i, if_sel_i, pwm_in_i};
    next_s.pin_s2 = s.pin_s1;
    next_s.pin_s3 = s.pin_s2;
    for (int b = 0; b < 4; b++) begin
      if (s.pin_s2[b] == s.pin_s3[b]) begin
        next_s.pin_f[b] = s.pin_s2[b];
      end
    end
    next_s.pin_q = s.pin_f;
    vdd_fall = s.pin_q[`LDC_PIN_VDD] && !s.pin_f[`LDC_PIN_VDD];
    next_s.i2c_sel = s.pin_f[`LDC_PIN_IFSEL];
    next_s.i2c_addr = s.pin_f[`LDC_PIN_ADDR] ? `LDC_I2C_ADDR1 : `LDC_I2C_ADDR0;

    // pwm pin duty is the high count over one output period
    next_s.cnt = s.cnt + 10'h001;
    if (s.cnt == 10'h3FF) begin
      next_s.pwm_brt = s.hi_cnt;
      next_s.hi_cnt = {9'h000, s.pin_f[`LDC_PIN_PWM]};
    end else if (s.pin_f[`LDC_PIN_PWM] && s.hi_cnt != 10'h3FF) begin
      next_s.hi_cnt = s.hi_cnt + 10'h001;
    end
    brt_global = brt_src_serial_i ? disp_brt_i[15:6] : s.pwm_brt;

    // strings are counted once, after the outputs settle
    unique case (s.phase)
      ldc_pkg::LDC_DETECT: begin
        next_s.det_cnt = s.det_cnt + 10'h001;
        if (s.det_cnt == 10'(`LDC_DETECT_CYC - 1)) begin
          next_s.present = string_present_i;
          next_s.phase = ldc_pkg::LDC_RUN;
        end
      end
      ldc_pkg::LDC_RUN: begin
        next_s.phase = ldc_pkg::LDC_RUN;
      end
    endcase
    active = (s.phase == ldc_pkg::LDC_RUN) ? s.present : 6'h00;

    // even phase spread over the strings actually present
    unique case (3'(rank[5] + {2'b00, s.present[5]}))
      3'd1: step = 10'd0;
      3'd2: step = 10'd512;
      3'd3: step = 10'd341;
      3'd4: step = 10'd256;
      3'd5: step = 10'd204;
      3'd6: step = 10'd170;
      default: step = 10'd0;
    endcase
    grp_split = cluster_group_i >= 3'd3 && cluster_group_i <= 3'd5;
    for (int c = 0; c < 6; c++) begin
      off_full = rank[c] * step;
      ch_off[c] = off_full[9:0];
      if (!cluster_en_i) begin
        ch_brt[c] = brt_global;
      end else if (grp_split && c < cluster_group_i) begin
        ch_brt[c] = chan_brt_i[15:6];
      end else begin
        ch_brt[c] = chan_brt_i[c*16+6 +: 10];
      end
    end

    // faulted strings drop out of headroom tracking too
    monitored = active & ~s.flt[`LDC_FLT_OPEN +: 6] & ~s.flt[`LDC_FLT_SHORT +: 6];
    next_s.boost_up = |(monitored & headroom_low_i);
    // a low string must win over all-high, never lower and raise together
    next_s.boost_down = !next_s.boost_up && (monitored != 6'h00) &&
                        ((monitored & headroom_high_i) == monitored);

    next_s.temp = temp_i;
    flt_set = {(temp_i < temp_lo_i) || (temp_i > temp_hi_i), tsd_i, vin_ocp_i, vin_uv_i, vin_ovp_i,
               vdd_uv_i, boost_ovp_i, boost_ocp_i, short_i & active, open_i & active};
    clr = fault_clr_i || vdd_fall;
    // a fault present during the clear survives it
    next_s.flt = clr ? flt_set : (s.flt | flt_set);
    next_s.int_oe = |next_s.flt;
  end

  always_comb begin
    rank[0] = 3'd0;
    for (int c = 1; c < 6; c++) begin
      rank[c] = 3'(rank[c-1] + {2'b00, s.present[c-1]});
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s <= '0;
      s.phase <= ldc_pkg::LDC_DETECT;
      s.i2c_addr <= `LDC_I2C_ADDR0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // channels
  for (genvar g = 0; g < 6; g++) begin : g_ch
    ldc_chan u_chan (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .cnt_i(s.cnt),
      .offset_i(ch_off[g]),
      .brt_i(ch_brt[g]),
      .scale_i(channel_current_scale_i[g*12 +: 12]),
      .hybrid_i(hybrid_en_i),
      .enable_i(active[g]),
      .pwm_o(led_pwm_o[g]),
      .cur_o(led_current_o[g*12 +: 12])
    );
  end

  assign i2c_sel_o = s.i2c_sel;
  assign i2c_addr_o = s.i2c_addr;
  assign strings_o = s.present;
  assign boost_up_o = s.boost_up;
  assign boost_down_o = s.boost_down;
  assign fault_status_o = s.flt;
  assign temp_o = s.temp;
  assign int_n_o = 1'b0;
  assign int_n_oe_o = s.int_oe;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence clr_req;
    fault_clr_i && !tsd_i;
  endsequence
  sequence tsd_cleared;
    !fault_status_o[`LDC_FLT_TSD];
  endsequence

  chk_src_pwm_pin: assert property (!brt_src_serial_i && !cluster_en_i |-> ch_brt[0] == s.pwm_brt)
    else $error("pwm pin brightness not used");
  chk_addr_pick: assert property (i2c_sel_o && $stable(s.pin_f) |=> i2c_addr_o ==
    ($past(s.pin_f[`LDC_PIN_ADDR]) ? `LDC_I2C_ADDR1 : `LDC_I2C_ADDR0)) else $error("wrong i2c address");
  chk_cluster_brt: assert property (cluster_en_i && !grp_split |-> ch_brt[5] == chan_brt_i[95:86])
    else $error("cluster brightness wrong");
  chk_host_clear: assert property (clr_req ##0 !vdd_fall |=> tsd_cleared)
    else $error("host clear ignored");
  chk_vdd_clear: assert property (vdd_fall && !boost_ocp_i |=> !fault_status_o[`LDC_FLT_BOCP])
    else $error("supply fall did not clear");
  chk_fault_sticky: assert property (boost_ovp_i ##1 !fault_clr_i && !vdd_fall |=>
    fault_status_o[`LDC_FLT_BOVP] [*1]) else $error("fault not latched");
  chk_unused_nofault: assert property (s.phase == ldc_pkg::LDC_RUN && !s.present[5] && !$rose(s.phase[1])
    |=> !fault_status_o[`LDC_FLT_OPEN + 5] || $past(fault_status_o[`LDC_FLT_OPEN + 5]))
    else $error("unused string faulted");
  chk_boost_up: assert property (|(monitored & headroom_low_i) |=> boost_up_o && !boost_down_o)
    else $error("boost not raised");
  chk_int_follow: assert property (|fault_status_o |-> int_n_oe_o && !int_n_o)
    else $error("interrupt not asserted");
  chk_iface_sel: assert property ($rose(s.pin_f[`LDC_PIN_IFSEL]) |=> i2c_sel_o)
    else $error("interface select not followed");
  chk_temp_window: assert property (temp_i > temp_hi_i |=> fault_status_o[`LDC_FLT_TWIN] ##0 temp_o == $past(temp_i))
    else $error("temperature window miss");
endmodule // ldc_top

// file: ldc_host_model.sv
// host side model: passes clear requests to the clear input one clock later
module ldc_host_model (
  input wire logic clk_i,
  input wire logic clr_req_i,
  output logic fault_clr_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // host clears latched faults on each cycle the request is held
  always @(posedge clk_i) begin
    fault_clr_o <= clr_req_i;
  end
endmodule // ldc_host_model

// file: ldc_top_tb.sv
// self-checking bench for the led backlight dimming control block
`include "ldc_defs.svh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module ldc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // stimulus, partner and design
  logic clk_i = 1'b0, reset_n_i = 1'b0, pwm = 1'b0, ifs = 1'b0, adp = 1'b0, vdd = 1'b1;
  logic srl = 1'b0, hyb = 1'b0, clu = 1'b0, clr_req = 1'b0, fclr;
  logic [15:0] disp = 16'h0000;
  logic [95:0] cbrt = '0;
  logic [71:0] scale = '0;
  logic [5:0] pres = 6'h0f, hl = 6'h00, hh = 6'h00, op = 6'h00, sh = 6'h00;
  logic [6:0] sf = 7'h00;
  logic [2:0] grp = 3'h0;
  logic [11:0] temp = 12'h0400, tlo = 12'h0100, thi = 12'h0800;
  logic i2c_sel, bup, bdn, int_n, int_oe;
  logic [6:0] addr;
  logic [5:0] led_pwm, strings;
  logic [71:0] led_cur;
  logic [19:0] flt, exp_flt;
  logic [11:0] temp_o;
  logic [31:0] seed = 32'h2a9c_610b;
  int errors = 0, n_compared = 0, i, j, c, b;
  int brt_tab[4] = '{1023, 256, 255, 16};

  ldc_host_model ldc_host_model_inst (.clk_i(clk_i), .clr_req_i(clr_req), .fault_clr_o(fclr));
  ldc_top ldc_top_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .pwm_in_i(pwm), .if_sel_i(ifs),
    .address_select_pin_i(adp), .vdd_i(vdd), .brt_src_serial_i(srl), .disp_brt_i(disp),
    .hybrid_en_i(hyb), .cluster_en_i(clu), .cluster_group_i(grp), .chan_brt_i(cbrt),
    .channel_current_scale_i(scale), .string_present_i(pres), .headroom_low_i(hl),
    .headroom_high_i(hh), .open_i(op), .short_i(sh), .boost_ocp_i(sf[0]), .boost_ovp_i(sf[1]),
    .vdd_uv_i(sf[2]), .vin_ovp_i(sf[3]), .vin_uv_i(sf[4]), .vin_ocp_i(sf[5]), .tsd_i(sf[6]),
    .temp_i(temp), .temp_lo_i(tlo), .temp_hi_i(thi), .fault_clr_i(fclr), .i2c_sel_o(i2c_sel),
    .i2c_addr_o(addr), .led_pwm_o(led_pwm), .led_current_o(led_cur), .strings_o(strings),
    .boost_up_o(bup), .boost_down_o(bdn), .fault_status_o(flt), .temp_o(temp_o),
    .int_n_o(int_n), .int_n_oe_o(int_oe));

  initial forever #50 clk_i = ~clk_i;
  // steady toggling keeps the pwm pin path exercised
  always @(posedge clk_i) pwm <= ~pwm;

  // ==========================================
  // reference model and helpers
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  function automatic int cur_exp(int s, int br, bit h);
    if (!h) return s;
    return (br >= 256) ? (s * br) / 1024 : s / 4;
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic clear();
    @(posedge clk_i) clr_req <= 1'b1;
    @(posedge clk_i) clr_req <= 1'b0;
    tick(3);
  endtask
  task automatic print_verdict();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================
  // scenarios
  initial begin
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    tick(510);
    `CHK("strings", 6'h0f, strings)
    for (i = 0; i < 4; i++) begin
      @(posedge clk_i) {adp, ifs} <= i[1:0];
      tick(6);
      `CHK("i2c_sel", i[0], i2c_sel)
      if (i[0]) `CHK("addr", i[1] ? `LDC_I2C_ADDR1 : `LDC_I2C_ADDR0, addr)
    end
    for (i = 0; i < 7; i++) begin
      @(posedge clk_i) sf <= 7'h01 << i;
      @(posedge clk_i) sf <= 7'h00;
      tick(2);
      exp_flt = 20'h0_1000 << i;
      `CHK("flt", exp_flt, flt)
      `CHK("int_oe", 1'b1, int_oe)
      `CHK("int_n", 1'b0, int_n)
      clear();
      `CHK("flt", 20'h0_0000, flt)
      `CHK("int_oe", 1'b0, int_oe)
    end
    // clear must lose against a cause still present
    @(posedge clk_i) sf <= 7'h02;
    clear();
    `CHK("flt held", 20'h0_2000, flt)
    @(posedge clk_i) sf <= 7'h00;
    clear();
    @(posedge clk_i) {op, sh} <= {6'h21, 6'h02};
    @(posedge clk_i) {op, sh} <= 12'h000;
    tick(2);
    `CHK("open short", 20'h0_0081, flt)
    @(posedge clk_i) vdd <= 1'b0;
    tick(6);
    `CHK("vdd clear", 20'h0_0000, flt)
    @(posedge clk_i) vdd <= 1'b1;
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      @(posedge clk_i) temp <= seed[11:0];
      tick(2);
      `CHK("temp", seed[11:0], temp_o)
      `CHK("twin", (seed[11:0] < tlo) || (seed[11:0] > thi), flt[19])
      @(posedge clk_i) temp <= 12'h0400;
      clear();
    end
    @(posedge clk_i) hl <= 6'h01;
    tick(2);
    `CHK("boost up", 1'b1, bup)
    @(posedge clk_i) hl <= 6'h20;
    tick(2);
    `CHK("unused up", 1'b0, bup)
    @(posedge clk_i) {hl, hh} <= {6'h00, 6'h0f};
    tick(2);
    `CHK("boost down", 1'b1, bdn)
    @(posedge clk_i) srl <= 1'b1;
    for (j = 0; j < 16; j++) begin
      seed = xs(seed);
      @(posedge clk_i);
      scale <= {seed[23:0], seed, seed[31:16]};
      cbrt <= {3{seed}};
      hyb <= j[0];
      clu <= j[1];
      disp <= {brt_tab[j[3:2]][9:0], 6'h00};
      grp <= j[3] ? 3'h4 : 3'h0;
      tick(3);
      for (c = 0; c < 4; c++) begin
        b = !clu ? brt_tab[j[3:2]] : int'(cbrt[(((grp >= 3'h3) && (c < grp)) ? 0 : c)*16+6 +: 10]);
        `CHK("cur", 12'(cur_exp(int'(scale[c*12 +: 12]), b, hyb)), led_cur[c*12 +: 12])
      end
      `CHK("unused pwm", 2'b00, led_pwm[5:4])
    end
    // quarter duty on four strings: an even spread lights exactly one output at a time
    @(posedge clk_i) {hyb, clu, disp} <= {2'b00, 16'h4000};
    tick(3);
    b = 0;
    c = 0;
    for (i = 0; i < 1024; i++) begin
      b += ($countones(led_pwm[3:0]) != 1);
      c += led_pwm[0];
      tick(0);
    end
    `CHK("one lit", 0, b)
    `CHK("ch0 duty", 256, c)
    print_verdict();
  end

  // run needs about 1770 cycles
  initial begin
    #400_000;
    errors++;
    $display("[FAIL] watchdog expired");
    print_verdict();
  end
endmodule // ldc_top_tb
